// ---- pas_top.sv ----
/*
  Bring-up sequencer for a PCI audio controller: APB registers, PLL and
  core clock gating, processor run and soft reset, second memory window
  and codec link control.
  Assumes an APB master on CLK_SYS and a codec driving the bit clock.
  PLL and processor sit outside; this block hands them
  enables and a reset. Window memories are a small stand-in of eight
  words per region. Writes land at the edge that takes the access.
*/
// The APB slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module pas_top
  import pas_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [19:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic AC_BIT_CLK,
  input wire logic AC_SDATA_IN,
  output logic AC_SYNC,
  output logic AC_SDATA_OUT,
  output logic AC_RESET_N,
  output logic PLL_POWER,
  output logic CORE_CLK_EN,
  output logic PROC_CLK_EN,
  output logic PROC_RESET,
  output logic DMA_REQ_EN
);
  // ****************************************************************
  // State
  // ****************************************************************
  // All state in one record: registers, window store, processor
  // controls and bus answer. One next-state copy keeps every flop
  // on the same synchronous reset.
  typedef struct packed {
    logic [15:0][31:0] regs;
    logic [31:0][31:0] mem;
    logic [31:0] frame_timer_count;
    logic run;
    logic srst;
    logic run_at_frame_bit;
    logic drq;
    logic running;
    logic [7:0] pll_cnt;
    logic pll_lock;
    logic core_en;
    logic proc_clk;
    logic proc_rst;
    logic dma_en;
    logic cmd_pend;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } pas_core_t;

  // Registered state and its next value
  pas_core_t q;
  pas_core_t n;
  // Carrier to the link front end
  pas_link_if l ();
  // Decoded view of the current bus request
  logic acc;
  logic reg_hit;
  logic win_hit;
  logic [1:0] region;
  logic [15:0] woff;
  logic [3:0] idx;

  // Read-only host registers hold link state, not stored values
  function automatic logic is_ro(input logic [3:0] i);
    return (i == IDX_LSTS) || (i == IDX_ISV) || (i == IDX_CSTAT) || (i == IDX_PCMIN);
  endfunction

  // ****************************************************************
  // Link front end
  // ****************************************************************
  // Bit clock and serial data are synchronised in here
  pas_link_fe u_fe (
    .clk(CLK_SYS),
    .rst_n(RST_N),
    .bit_clk(AC_BIT_CLK),
    .sdata_in(AC_SDATA_IN),
    .sync(AC_SYNC),
    .sdata_out(AC_SDATA_OUT),
    .l(l.fe)
  );

  // Link controls straight from host registers. Command word packed
  // into slot layout here so the front end only shifts bits; a
  // command written mid-frame waits for the next frame start.
  assign l.sync_en = q.regs[IDX_LCTL][LCTL_SYNC];
  assign l.valid_frame = q.regs[IDX_LCTL][LCTL_VFRM];
  assign l.out_valid = q.regs[IDX_OSV][1:0];
  assign l.cmd_valid = q.cmd_pend;
  assign l.cmd_w1 = {q.regs[IDX_CMD][24], q.regs[IDX_CMD][22:16], 12'h000};
  assign l.cmd_w2 = {q.regs[IDX_CMD][15:0], 4'h0};
  assign l.pcm_out = q.regs[IDX_PCMOUT];

  // ****************************************************************
  // Address decode
  // ****************************************************************
  // A new access is taken only once; pready high ends it. Masking
  // with the registered answer stops a held access being taken twice.
  // No byte lanes: PADDR[1:0] is ignored except in the processor region, where offsets are compared whole.
  assign acc = PSEL & PENABLE & ~q.pready;
  // Host registers in the first 64 bytes, window above
  assign reg_hit = (PADDR[19:6] == 14'h0000);
  assign win_hit = (PADDR[19:18] == WIN_BASE[19:18]);
  assign region = PADDR[17:16];
  assign woff = PADDR[15:0];
  assign idx = PADDR[5:2];

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    // Hold every field; answer pulses fall back to zero
    n = q;
    n.pready = 1'b0;
    n.pslverr = 1'b0;
    // Command slot consumed; a write in the same cycle sets it again
    if (l.cmd_taken)
      n.cmd_pend = 1'b0;
    // Every taken access answers next cycle, refused ones too, so
    // the bus never stalls on the processor side
    if (acc)
    begin
      n.pready = 1'b1;
      n.prdata = 32'h00000000;
      if (reg_hit)
      begin
        // Read-only indexes show link state; writes are dropped
        if (PWRITE && !is_ro(idx))
          n.regs[idx] = PWDATA;
        // Command write queues one frame of slots one and two
        if (PWRITE && idx == IDX_CMD)
          n.cmd_pend = 1'b1;
        // Live link state for read-only indexes, else stored word
        unique case (idx)
          IDX_LSTS: n.prdata = {30'h00000000, l.alive, l.rx_tag[TAG_VALID]};
          IDX_ISV: n.prdata = {30'h00000000, l.rx_tag[TAG_S4], l.rx_tag[TAG_S3]};
          // Index from slot one, data from slot two
          IDX_CSTAT: n.prdata = {9'h000, l.rx_s1[18:12], l.rx_s2[19:4]};
          IDX_PCMIN: n.prdata = l.rx_pcm;
          default: n.prdata = q.regs[idx];
        endcase
      end
      // Window belongs to the processor domain; without core clock
      // it answers but has no effect
      else if (win_hit)
      begin
        if (q.core_en)
        begin
          if (region != WIN_PROC[17:16])
          begin
            if (woff[15:5] != 11'h000)
              n.pslverr = 1'b1;
            else if (PWRITE)
              n.mem[{region, woff[4:2]}] = PWDATA;
            else
              n.prdata = q.mem[{region, woff[4:2]}];
          end
          else if (woff == PROC_CTRL_OFF)
          begin
            // Controls written together; soft reset below then
            // overrides the run bits in the same cycle
            if (PWRITE)
            begin
              n.run = PWDATA[CTRL_RUN];
              n.srst = PWDATA[CTRL_SRST];
              n.run_at_frame_bit = PWDATA[CTRL_RUN_AT_FRAME_BIT];
              n.drq = PWDATA[CTRL_DRQ];
            end
            // Readback shows the controls before this write
            n.prdata[CTRL_RUN] = q.run;
            n.prdata[CTRL_SRST] = q.srst;
            n.prdata[CTRL_RUN_AT_FRAME_BIT] = q.run_at_frame_bit;
            n.prdata[CTRL_DRQ] = q.drq;
          end
          else if (woff == PROC_STAT_OFF)
            n.prdata = {31'h00000000, q.running};
          else if (woff == FRAME_TIMER_COUNT_OFF)
          begin
            if (PWRITE)
              n.frame_timer_count = PWDATA;
            n.prdata = q.frame_timer_count;
          end
          else
            n.pslverr = 1'b1;
        end
      end
      else
        n.pslverr = 1'b1;
    end
    // No lock signal comes back, so settling is a fixed count;
    // dropping PLL power restarts it
    // PLL settle timer
    if (!q.regs[IDX_CLK1][CLK1_PLL_PWR])
    begin
      n.pll_cnt = 8'h00;
      n.pll_lock = 1'b0;
    end
    else if (q.pll_cnt == PLL_SETTLE_LAST)
      n.pll_lock = 1'b1;
    else
      n.pll_cnt = q.pll_cnt + 8'h01;
    // Bit clock loss drops the core clock at once: the PLL would
    // drift without its reference
    // core clock gate
    n.core_en = q.regs[IDX_CLK1][CLK1_CORE_EN] & q.pll_lock & l.alive;
    // Start waits for a frame boundary, so processor sees whole frames
    // run-at-frame takes effect
    if (q.core_en && l.frame_start && q.run && q.run_at_frame_bit && !q.srst)
    begin
      n.run_at_frame_bit = 1'b0;
      n.running = 1'b1;
    end
    // Soft reset wins over anything written in the same cycle
    // soft reset immediate
    if (n.srst)
    begin
      n.run = 1'b0;
      n.run_at_frame_bit = 1'b0;
      n.drq = 1'b0;
      n.running = 1'b0;
    end
    // Running also needs run set and the core clock present
    // halted without run
    if (!n.run || !q.core_en)
      n.running = 1'b0;
    // Processor pins follow the next state, registered at the same edge as it
    n.proc_clk = q.core_en & n.running;
    n.proc_rst = n.srst;
    n.dma_en = n.drq & n.running;
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // Reset keeps the processor clocked and held, so its state is
  // flushed before the clock stops at release
  // processor clocked during reset
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
    begin
      q <= '0;
      q.proc_clk <= 1'b1;
      q.proc_rst <= 1'b1;
    end
    else
      q <= n;
  end

  // Outputs straight from flops, so pins never glitch while the
  // host rewrites a register or the bit clock stops
  assign PRDATA = q.prdata;
  assign PREADY = q.pready;
  assign PSLVERR = q.pslverr;
  assign AC_RESET_N = q.regs[IDX_LCTL][LCTL_NRST];
  assign PLL_POWER = q.regs[IDX_CLK1][CLK1_PLL_PWR];
  assign CORE_CLK_EN = q.core_en;
  assign PROC_CLK_EN = q.proc_clk;
  assign PROC_RESET = q.proc_rst;
  assign DMA_REQ_EN = q.dma_en;
endmodule
`default_nettype wire

// ---- pas_pkg.sv ----
/*
  Shared constants for the audio controller bring-up block: register
  indexes, window layout, control bit positions and timing counts.
  Assumes a 100 MHz system clock and an APB register bus.
*/
`default_nettype none
package pas_pkg;
  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int CLK_HZ = 100_000_000;
  localparam int PLL_SETTLE_NS = 2000;
  localparam int PLL_SETTLE_CYC = (PLL_SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam logic [7:0] PLL_SETTLE_LAST = 8'(PLL_SETTLE_CYC - 1);
  // Bit clock counts as dead after one cycle more than this without an edge
  localparam logic [5:0] BCLK_TMO_LAST = 6'h1f;
  // ****************************************************************
  // Host register indexes (byte address = 4 * index)
  // ****************************************************************
  localparam logic [3:0] IDX_CLK1 = 4'h0;
  localparam logic [3:0] IDX_CLK2 = 4'h1;
  localparam logic [3:0] IDX_PLLCFG = 4'h2;
  localparam logic [3:0] IDX_PLLMUL = 4'h3;
  localparam logic [3:0] IDX_SERMC = 4'h4;
  localparam logic [3:0] IDX_SERIAL_PORT_CFG_ONE = 4'h5;
  localparam logic [3:0] IDX_SERIAL_PORT_CFG_TWO = 4'h6;
  localparam logic [3:0] IDX_CTYPE = 4'h7;
  localparam logic [3:0] IDX_LCTL = 4'h8;
  localparam logic [3:0] IDX_LSTS = 4'h9;
  localparam logic [3:0] IDX_ISV = 4'ha;
  localparam logic [3:0] IDX_OSV = 4'hb;
  localparam logic [3:0] IDX_CMD = 4'hc;
  localparam logic [3:0] IDX_CSTAT = 4'hd;
  localparam logic [3:0] IDX_PCMIN = 4'he;
  localparam logic [3:0] IDX_PCMOUT = 4'hf;
  // ****************************************************************
  // Second memory window
  // ****************************************************************
  localparam logic [19:0] WIN_BASE = 20'h40000;
  localparam logic [19:0] WIN_PARAM = 20'h00000;
  localparam logic [19:0] WIN_SAMPLE = 20'h10000;
  localparam logic [19:0] WIN_CODE = 20'h20000;
  localparam logic [19:0] WIN_PROC = 20'h30000;
  localparam logic [15:0] PROC_CTRL_OFF = 16'h0000;
  localparam logic [15:0] PROC_STAT_OFF = 16'h0004;
  localparam logic [15:0] FRAME_TIMER_COUNT_OFF = 16'h0008;
  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CTRL_RUN = 0;
  localparam int CTRL_SRST = 1;
  localparam int CTRL_RUN_AT_FRAME_BIT = 2;
  localparam int CTRL_DRQ = 5;
  localparam int CLK1_PLL_PWR = 4;
  localparam int CLK1_CORE_EN = 5;
  localparam int LCTL_NRST = 0;
  localparam int LCTL_SYNC = 1;
  localparam int LCTL_VFRM = 2;
  localparam int TAG_VALID = 15;
  localparam int TAG_S1 = 14;
  localparam int TAG_S2 = 13;
  localparam int TAG_S3 = 12;
  localparam int TAG_S4 = 11;
  // ****************************************************************
  // Link frame layout
  // ****************************************************************
  localparam logic [4:0] SLOT0_TOP = 5'h0f;
  localparam logic [4:0] SLOT_TOP = 5'h13;
  localparam logic [3:0] LAST_SLOT = 4'hc;
endpackage
`default_nettype wire

// ---- pas_link_if.sv ----
/*
  Signals between the register core and the link front end.
  Assumes both ends run on the system clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface pas_link_if;
  logic sync_en;
  logic valid_frame;
  logic [1:0] out_valid;
  logic cmd_valid;
  logic [19:0] cmd_w1;
  logic [19:0] cmd_w2;
  logic [31:0] pcm_out;
  logic alive;
  logic frame_start;
  logic cmd_taken;
  logic [15:0] rx_tag;
  logic [19:0] rx_s1;
  logic [19:0] rx_s2;
  logic [31:0] rx_pcm;
  modport core (output sync_en, valid_frame, out_valid, cmd_valid, cmd_w1, cmd_w2,
    pcm_out, input alive, frame_start, cmd_taken, rx_tag, rx_s1, rx_s2, rx_pcm);
  modport fe (input sync_en, valid_frame, out_valid, cmd_valid, cmd_w1, cmd_w2,
    pcm_out, output alive, frame_start, cmd_taken, rx_tag, rx_s1, rx_s2, rx_pcm);
endinterface
`default_nettype wire

// ---- pas_link_fe.sv ----
/*
  Link front end: samples the codec bit clock, frames slots, drives
  sync and serial out, captures serial in.
  Assumes the bit clock is well below half the system clock.
*/
`timescale 1ns/1ps
`default_nettype none
module pas_link_fe
  import pas_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic bit_clk,
  input wire logic sdata_in,
  output logic sync,
  output logic sdata_out,
  pas_link_if.fe l
);
  typedef struct packed {
    logic bclk_s1;
    logic bclk_s2;
    logic bclk_d;
    logic sdin_s1;
    logic sdin_s2;
    logic [5:0] tmo;
    logic alive;
    logic [3:0] slot;
    logic [4:0] bitn;
    logic sync;
    logic sdout;
    logic [15:0] tx_tag;
    logic [19:0] tx_w1;
    logic [19:0] tx_w2;
    logic [31:0] tx_pcm;
    logic [19:0] rx_sh;
    logic [15:0] rx_tag;
    logic [19:0] rx_s1;
    logic [19:0] rx_s2;
    logic [31:0] rx_pcm;
    logic frame_start;
    logic cmd_taken;
  } pas_fe_t;

  pas_fe_t q;
  pas_fe_t n;
  logic rise;
  logic fall;

  // Bit of the outgoing frame at a given slot and position
  function automatic logic tx_bit(input pas_fe_t s);
    logic [19:0] w;
    w = 20'h00000;
    unique case (s.slot)
      4'h0: w = {4'h0, s.tx_tag};
      4'h1: w = s.tx_w1;
      4'h2: w = s.tx_w2;
      4'h3: w = {s.tx_pcm[31:16], 4'h0};
      4'h4: w = {s.tx_pcm[15:0], 4'h0};
      default: w = 20'h00000;
    endcase
    return w[s.bitn];
  endfunction

  // Edges come from the second and third stages, never the first
  assign rise = q.bclk_s2 & ~q.bclk_d;
  assign fall = ~q.bclk_s2 & q.bclk_d;

  // Next state of the whole front end
  always_comb
  begin
    n = q;
    n.frame_start = 1'b0;
    n.cmd_taken = 1'b0;
    n.bclk_s1 = bit_clk;
    n.bclk_s2 = q.bclk_s1;
    n.bclk_d = q.bclk_s2;
    n.sdin_s1 = sdata_in;
    n.sdin_s2 = q.sdin_s1;
    if (rise | fall)
    begin
      n.tmo = 6'h00;
      n.alive = 1'b1;
    end
    else if (q.tmo == BCLK_TMO_LAST)
      n.alive = 1'b0;
    else
      n.tmo = q.tmo + 6'h01;
    if (!l.sync_en)
    begin
      n.slot = LAST_SLOT;
      n.bitn = 5'h00;
      n.sync = 1'b0;
      n.sdout = 1'b0;
    end
    else if (rise)
    begin
      if (q.bitn == 5'h00)
      begin
        n.slot = (q.slot == LAST_SLOT) ? 4'h0 : q.slot + 4'h1;
        n.bitn = (n.slot == 4'h0) ? SLOT0_TOP : SLOT_TOP;
        if (n.slot == 4'h0)
        begin
          n.frame_start = 1'b1;
          n.cmd_taken = l.cmd_valid;
          n.tx_tag = 16'h0000;
          n.tx_tag[TAG_VALID] = l.valid_frame;
          n.tx_tag[TAG_S1] = l.cmd_valid;
          n.tx_tag[TAG_S2] = l.cmd_valid;
          n.tx_tag[TAG_S3] = l.out_valid[0];
          n.tx_tag[TAG_S4] = l.out_valid[1];
          n.tx_w1 = l.cmd_valid ? l.cmd_w1 : 20'h00000;
          n.tx_w2 = l.cmd_valid ? l.cmd_w2 : 20'h00000;
          n.tx_pcm = l.pcm_out;
        end
      end
      else
        n.bitn = q.bitn - 5'h01;
      n.sync = (n.slot == 4'h0);
      n.sdout = tx_bit(n);
    end
    else if (fall)
    begin
      n.rx_sh = {q.rx_sh[18:0], q.sdin_s2};
      if (q.bitn == 5'h00)
      begin
        unique case (q.slot)
          4'h0: n.rx_tag = n.rx_sh[15:0];
          4'h1: n.rx_s1 = n.rx_sh;
          4'h2: n.rx_s2 = n.rx_sh;
          4'h3: n.rx_pcm[31:16] = n.rx_sh[19:4];
          4'h4: n.rx_pcm[15:0] = n.rx_sh[19:4];
          default: n.rx_sh = n.rx_sh;
        endcase
      end
    end
  end

  // State register, synchronous reset
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      q <= '0;
    else
      q <= n;
  end

  assign sync = q.sync;
  assign sdata_out = q.sdout;
  assign l.alive = q.alive;
  assign l.frame_start = q.frame_start;
  assign l.cmd_taken = q.cmd_taken;
  assign l.rx_tag = q.rx_tag;
  assign l.rx_s1 = q.rx_s1;
  assign l.rx_s2 = q.rx_s2;
  assign l.rx_pcm = q.rx_pcm;
endmodule
`default_nettype wire

// ---- pas_sva.sv ----
/*
  Port checker for the bring-up block.
  Assumes it is bound to pas_top and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module pas_sva
  import pas_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [19:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic AC_BIT_CLK,
  input wire logic AC_SDATA_IN,
  input wire logic AC_SYNC,
  input wire logic AC_SDATA_OUT,
  input wire logic AC_RESET_N,
  input wire logic PLL_POWER,
  input wire logic CORE_CLK_EN,
  input wire logic PROC_CLK_EN,
  input wire logic PROC_RESET,
  input wire logic DMA_REQ_EN
);
  // ****************************************
  // Helpers and properties
  // ****************************************
  localparam logic [19:0] CTRL_A = WIN_BASE + WIN_PROC;
  logic [7:0] pll_cnt_d;
  logic [7:0] pll_cnt_q;
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_N);
  // Cycles since PLL power, saturating so it never wraps
  always_comb
  begin
    pll_cnt_d = (pll_cnt_q == 8'hff) ? pll_cnt_q : pll_cnt_q + 8'h01;
    if (!PLL_POWER)
      pll_cnt_d = 8'h00;
  end
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
      pll_cnt_q <= 8'h00;
    else
      pll_cnt_q <= pll_cnt_d;
  end
  // Access taken, then its one-cycle answer
  sequence s_take;
    PSEL && PENABLE && !PREADY;
  endsequence
  sequence s_answer;
    PREADY ##1 !PREADY;
  endsequence
  a_apb_one_wait: assert property (s_take |-> ##1 s_answer)
    else $error("bus answer not after one wait state");
  a_unmapped_err: assert property (s_take ##0 PADDR[19] |-> ##1 PSLVERR)
    else $error("no error on unmapped address");
  a_window_gated: assert property (s_take ##0 (PADDR[19:18] == 2'b01 && !CORE_CLK_EN &&
    !PWRITE) |-> ##1 (PRDATA == 32'h0 && !PSLVERR))
    else $error("window answered without core clock");
  a_core_after_pll: assert property ($rose(CORE_CLK_EN) |-> pll_cnt_q > PLL_SETTLE_LAST)
    else $error("core clock before PLL settled");
  a_core_needs_pll: assert property (CORE_CLK_EN |-> PLL_POWER || $past(PLL_POWER))
    else $error("core clock without PLL power");
  a_proc_halted: assert property (!CORE_CLK_EN [*2] ##0 $past(RST_N) |-> !PROC_CLK_EN)
    else $error("processor clocked without core clock");
  a_reset_flush: assert property (RST_N && !$past(RST_N) |->
    (PROC_CLK_EN && PROC_RESET) ##1 (!PROC_CLK_EN && !PROC_RESET))
    else $error("processor not flushed then stopped");
  a_soft_reset_now: assert property (s_take ##0 (PWRITE && PADDR[19:2] == CTRL_A[19:2] &&
    PWDATA[CTRL_SRST] && CORE_CLK_EN) |-> ##2 (PROC_RESET && !DMA_REQ_EN))
    else $error("soft reset not applied at once");
  a_halt_after_srst: assert property ($fell(PROC_RESET) |-> !PROC_CLK_EN [*4])
    else $error("processor runs after soft reset");
endmodule
bind pas_top pas_sva i_sva (.CLK_SYS, .RST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
  .PRDATA, .PREADY, .PSLVERR, .AC_BIT_CLK, .AC_SDATA_IN, .AC_SYNC, .AC_SDATA_OUT,
  .AC_RESET_N, .PLL_POWER, .CORE_CLK_EN, .PROC_CLK_EN, .PROC_RESET, .DMA_REQ_EN);
`default_nettype wire

// ---- pas_codec_model.sv ----
/*
  Codec partner: makes the bit clock, sends status frames, keeps the
  tag of each output frame. Assumes sync rises at frame start.
*/
`timescale 1ns/1ps
`default_nettype none
module pas_codec_model #(
  parameter int READY_FRAMES = 3
) (
  input wire logic reset_n,
  input wire logic sync,
  input wire logic sdata_out,
  output logic bit_clk,
  output logic sdata_in,
  output logic [15:0] out_tag
);
  // ****************************************
  // Link behaviour
  // ****************************************
  int idx = 256;
  int frames = 0;
  logic rdy;
  logic [255:0] frame;
  // bit clock first, stopped in codec reset
  initial
  begin
    bit_clk = 1'b0;
    forever
    begin
      #62.5;
      bit_clk = reset_n ? ~bit_clk : 1'b0;
    end
  end
  // ready and slots valid only after a few frames (slow codec)
  assign rdy = frames > READY_FRAMES;
  // status in slots 1-2, samples in slots 3-4
  assign frame = {rdy, 2'b00, rdy, rdy, 11'h000, 20'h26000, 20'h5a5a0, 20'h12340,
    20'hbeef0, 160'h0};
  // Toggle between frames so a stale bit is never read as data
  assign sdata_in = (idx < 256) ? frame[255 - idx] : bit_clk;
  always @(posedge sync)
  begin
    idx = 0;
    frames = frames + 1;
  end
  always @(posedge bit_clk)
  begin
    if (idx < 256)
      idx = idx + 1;
  end
  // Output tag sampled where the controller samples its input
  always @(negedge bit_clk)
  begin
    if (idx < 16)
      out_tag[15 - idx] <= sdata_out;
  end
endmodule
`default_nettype wire

// ---- pas_tb.sv ----
/*
  Self-checking bench for pas_top with a codec model on the link.
  Assumes a fixed PLL settle time; bus tasks wait for ready.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench
  import pas_pkg::*;
;
  // ****************************************
  // Signals, bus tasks, checks
  // ****************************************
  localparam logic [19:0] CTRL = WIN_BASE + WIN_PROC;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [19:0] paddr = 20'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, bclk, sdi, sync, sdo, ac_rst_n, err;
  logic pll_pwr, core_en, proc_en, proc_rst, dma_en;
  logic [15:0] tag;
  int num_errors = 0;
  int checked = 0;
  int cycles = 0;
  always #5 clk = ~clk;
  pas_top i_dut (.CLK_SYS(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .AC_BIT_CLK(bclk), .AC_SDATA_IN(sdi), .AC_SYNC(sync),
    .AC_SDATA_OUT(sdo), .AC_RESET_N(ac_rst_n), .PLL_POWER(pll_pwr), .CORE_CLK_EN(core_en),
    .PROC_CLK_EN(proc_en), .PROC_RESET(proc_rst), .DMA_REQ_EN(dma_en));
  pas_codec_model i_codec (.reset_n(ac_rst_n), .sync(sync), .sdata_out(sdo),
    .bit_clk(bclk), .sdata_in(sdi), .out_tag(tag));
  function automatic logic [19:0] ra(input logic [3:0] i);
    return {14'h0, i, 2'b00};
  endfunction
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Setup, then access held until ready is seen at an edge
  task automatic apb(input logic w, input logic [19:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      #1;
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    chk("bus answer", {31'h0, pready}, 32'h1);
    rd = prdata;
    err = pslverr;
    // Release only after the edge that samples ready high
    @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [19:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input string nm, input logic [19:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, rd, exp);
  endtask
  task automatic poll(input logic [19:0] a, input logic [31:0] m, input logic [31:0] v);
    int n;
    n = 0;
    do
    begin
      apb(1'b0, a, 32'h0);
      n++;
    end
    while ((rd & m) !== v && n < 5000);
    chk("polled field", rd & m, v);
  endtask
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    chk("idle clocks", {29'h0, proc_en, proc_rst, core_en}, 32'h0);
    wr(CTRL, 32'h25);
    rdc("gated read", CTRL, 32'h0);
    chk("gated error", {31'h0, err}, 32'h0);
    chk("gated run", {31'h0, proc_en}, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_bringup();
    wr(ra(IDX_CLK1), 32'h0);
    wr(ra(IDX_SERMC), 32'h0);
    wr(ra(IDX_CTYPE), 32'h8);
    wr(ra(IDX_CTYPE), 32'h9);
    rdc("codec type", ra(IDX_CTYPE), 32'h9);
    wr(ra(IDX_LCTL), 32'h1);
    chk("codec reset", {31'h0, ac_rst_n}, 32'h1);
    wr(ra(IDX_LCTL), 32'h3);
    wr(ra(IDX_SERMC), 32'h2);
    wr(ra(IDX_PLLCFG), 32'h7e);
    wr(ra(IDX_PLLMUL), 32'h3a);
    wr(ra(IDX_CLK2), 32'h8);
    wr(ra(IDX_CLK1), 32'h10);
    wr(ra(IDX_CLK1), 32'h30);
    settle();
    chk("core early", {30'h0, pll_pwr, core_en}, 32'h2);
    repeat (250) @(posedge clk);
    #1;
    chk("core on", {31'h0, core_en}, 32'h1);
    wr(ra(IDX_SERIAL_PORT_CFG_ONE), 32'h3);
    wr(ra(IDX_SERIAL_PORT_CFG_TWO), 32'h3);
    wr(ra(IDX_SERMC), 32'h3);
    poll(ra(IDX_LSTS), 32'h1, 32'h1);
    wr(ra(IDX_LCTL), 32'h7);
    poll(ra(IDX_ISV), 32'h3, 32'h3);
    wr(ra(IDX_OSV), 32'h3);
    repeat (6500) @(posedge clk);
    chk("out tag", {16'h0, tag & 16'hf800}, 32'h9800);
    rdc("codec status", ra(IDX_CSTAT), 32'h00265a5a);
    rdc("pcm in", ra(IDX_PCMIN), 32'h1234beef);
    $display("test bring-up done");
  endtask
  task automatic t_window();
    logic [19:0] a;
    logic [19:0] bad [3] = '{20'h40020, 20'h80000, 20'h00040};
    for (int i = 0; i < 3; i++)
      wr(WIN_BASE + (20'(i) << 16) + 20'(4 * i), 32'h11111111 * 32'(i + 1));
    for (int i = 0; i < 3; i++)
    begin
      a = WIN_BASE + (20'(i) << 16) + 20'(4 * i);
      rdc("window word", a, 32'h11111111 * 32'(i + 1));
      apb(1'b0, bad[i], 32'h0);
      chk("unmapped error", {31'h0, err}, 32'h1);
    end
    $display("test window done");
  endtask
  task automatic t_start();
    wr(CTRL + 20'h8, 32'hadf);
    rdc("timer", CTRL + 20'h8, 32'hadf);
    rdc("saved playback", WIN_BASE, 32'h11111111);
    wr(WIN_BASE, 32'h0);
    wr(WIN_BASE + 20'h4, 32'h0);
    rdc("playback zero", WIN_BASE, 32'h0);
    rdc("capture zero", WIN_BASE + 20'h4, 32'h0);
    wr(CTRL, 32'h25);
    poll(CTRL, 32'h4, 32'h0);
    poll(CTRL + 20'h4, 32'h1, 32'h1);
    rdc("run bits", CTRL, 32'h21);
    settle();
    chk("running", {30'h0, proc_en, dma_en}, 32'h3);
    $display("test start done");
  endtask
  task automatic t_srst();
    wr(CTRL, 32'h2);
    settle();
    chk("soft reset", {29'h0, proc_rst, proc_en, dma_en}, 32'h4);
    rdc("stopped", CTRL + 20'h4, 32'h0);
    wr(CTRL, 32'h0);
    settle();
    chk("halted", {30'h0, proc_rst, proc_en}, 32'h0);
    rdc("run clear", CTRL, 32'h0);
    $display("test soft reset done");
  endtask
  // Hang guard: ceiling well above the expected run
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      num_errors++;
      tally_and_finish();
    end
  end
  initial
  begin
    repeat (4) @(posedge clk);
    chk("flush", {30'h0, proc_en, proc_rst}, 32'h3);
    rst_n <= 1'b1;
    settle();
    t_reset();
    t_bringup();
    t_window();
    t_start();
    t_srst();
    tally_and_finish();
  end
endmodule
`default_nettype wire
